//--- design/dcc_edge.sv
// pin sampler and edge detector for one capture channel
`timescale 1ns/1ps
`default_nettype none
module dcc_edge (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // pin level
  input wire logic i_pin,
  // one-cycle edge pulses
  output logic o_rise,
  output logic o_fall
);
  logic smp;
  logic prev;

  // two consecutive samples; edges come only from these
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      smp <= 1'b0;
      prev <= 1'b0;
    end else begin
      smp <= i_pin;
      prev <= smp;
    end
  end

  assign o_rise = smp & ~prev;
  assign o_fall = ~smp & prev;
endmodule
`default_nettype wire

//--- design/dcc_pkg.sv
// package: register map, field layout, mode codes and bus carrier for the capture/compare unit
package dcc_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_FLAGS_ONE = 8'h0c;
  localparam logic [7:0] IDX_FLAGS_TWO = 8'h0d;
  localparam logic [7:0] IDX_CH1_LOW = 8'h15;
  localparam logic [7:0] IDX_CH1_HIGH = 8'h16;
  localparam logic [7:0] IDX_CH1_CTRL = 8'h17;
  localparam logic [7:0] IDX_CH2_LOW = 8'h1b;
  localparam logic [7:0] IDX_CH2_HIGH = 8'h1c;
  localparam logic [7:0] IDX_CH2_CTRL = 8'h1d;
  localparam logic [7:0] IDX_EN_ONE = 8'h8c;
  localparam logic [7:0] IDX_EN_TWO = 8'h8d;

  // field positions
  localparam int unsigned FLAG_CH1_BIT = 2;
  localparam int unsigned FLAG_TIMER_ONE_COUNT_BIT = 0;
  localparam int unsigned FLAG_CH2_BIT = 0;
  localparam int unsigned EN_CH1_BIT = 2;
  localparam int unsigned EN_CH2_BIT = 0;
  localparam int unsigned CTRL_WIDTH = 6;

  // values after reset
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] ENABLES_RESET = 8'h00;
  localparam logic [5:0] CTRL_RESET = 6'h00;
  localparam logic [15:0] VALUE_RESET = 16'h0000;

  // mode field codes
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
  localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
  localparam logic [3:0] MODE_CMP_HIGH = 4'h8;
  localparam logic [3:0] MODE_CMP_LOW = 4'h9;
  localparam logic [3:0] MODE_CMP_SOFT = 4'ha;
  localparam logic [3:0] MODE_CMP_SPECIAL = 4'hb;
  localparam logic [1:0] GROUP_CAPTURE = 2'h1;
  localparam logic [1:0] GROUP_COMPARE = 2'h2;

  // prescaler terminal counts (edges minus one)
  localparam logic [3:0] PRESC_TERM_1 = 4'h0;
  localparam logic [3:0] PRESC_TERM_4 = 4'h3;
  localparam logic [3:0] PRESC_TERM_16 = 4'hf;

  // apb request carrier
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [9:0] paddr;
    logic [31:0] pwdata;
  } dcc_apb_req_t;

endpackage

//--- design/dcc_presc.sv
// capture prescaler: counts rising edges and ticks at the terminal count
`timescale 1ns/1ps
`default_nettype none
module dcc_presc (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // control
  input wire logic i_clear,
  input wire logic i_rise,
  input wire logic [3:0] i_term,
  // tick on the qualifying edge
  output logic o_tick
);
  logic [3:0] cnt;
  logic [3:0] next_cnt;

  // a count left above the new terminal by a divider switch ticks on the next rising edge
  assign o_tick = i_rise & (cnt >= i_term);
  // clear dominates; a mode switch between dividers keeps the count
  assign next_cnt = i_clear ? 4'h0 : (o_tick ? 4'h0 : (i_rise ? cnt + 4'h1 : cnt));

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      cnt <= 4'h0;
    end else begin
      cnt <= next_cnt;
    end
  end
endmodule
`default_nettype wire

//--- design/dcc_top.sv
// dual capture/compare unit with apb register slave
//
// Contract
// [R1] one 16-bit value register per channel
// [R2] value bytes and control are read/write
// [R3] channels identical except special trigger action
// [R4] capture copies full timer count
// [R5] mode selects fall, rise, 4th, 16th rise
// [R6] capture sets flag; only software clears
// [R7] new capture overwrites value unconditionally
// [R8] edge detector watches the pin level
// [R9] software sets pin direction per mode
// [R10] software runs timer synchronously
// [R11] software masks enable while changing mode
// [R12] prescaler cleared when off or not capturing
// [R13] switching prescaler keeps count, may flag
// [R14] compare value against timer for equality
// [R15] match drives pin, sets flag simultaneously
// [R16] zero control write clears compare latch
// [R17] soft mode: flag only, pin untouched
// [R18] channel one special trigger resets timer
// [R19] channel two also starts conversion if enabled
// [R20] channel two reset leaves overflow flag alone
// [R21] software uses special trigger when sharing
// [R22] pin sampled on clock, single-cycle capture
// [R23] zero is off; codes map one-to-one
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module dcc_top (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // apb slave
  input wire dcc_pkg::dcc_apb_req_t i_apb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // timer one interface
  input wire logic [15:0] i_timer_count,
  input wire logic i_timer_overflow,
  output logic o_timer_reset,
  // converter interface
  input wire logic i_adc_enabled,
  output logic o_adc_start,
  // channel pins
  input wire logic [1:0] i_chan_pin,
  output logic [1:0] o_chan_out,
  // flag and enable both set, per channel
  output logic [1:0] o_event_req
);
  import dcc_pkg::*;

  // bus decode
  wire setup_phase;
  wire access_phase;
  wire wr_access;
  wire addr_aligned;
  wire [7:0] idx;
  wire [7:0] wbyte;
  wire hit_flags_one;
  wire hit_flags_two;
  wire hit_en_one;
  wire hit_en_two;
  wire [1:0] hit_low;
  wire [1:0] hit_high;
  wire [1:0] hit_ctrl;
  wire mapped;

  // per-channel views gathered from the generate loop
  wire [1:0][15:0] value_w;
  wire [1:0][5:0] ctrl_w;
  wire [1:0] set_flag;
  wire [1:0] special_hit;

  // shared registers
  logic [7:0] flags_one;
  logic [7:0] flags_two;
  logic [7:0] enables_one;
  logic [7:0] enables_two;
  logic [7:0] next_flags_one;
  logic [7:0] next_flags_two;
  logic [31:0] next_prdata;
  logic [7:0] rd_byte;
  logic next_timer_reset;
  logic next_adc_start;

  // apb phases; the slave never inserts wait states
  assign setup_phase = i_apb.psel & ~i_apb.penable;
  assign access_phase = i_apb.psel & i_apb.penable;
  assign wr_access = access_phase & i_apb.pwrite;
  assign addr_aligned = (i_apb.paddr[1:0] == 2'h0);
  assign idx = i_apb.paddr[9:2];
  assign wbyte = i_apb.pwdata[7:0];
  assign o_pready = access_phase;

  // register selects, word aligned only
  assign hit_flags_one = addr_aligned & (idx == IDX_FLAGS_ONE);
  assign hit_flags_two = addr_aligned & (idx == IDX_FLAGS_TWO);
  assign hit_en_one = addr_aligned & (idx == IDX_EN_ONE);
  assign hit_en_two = addr_aligned & (idx == IDX_EN_TWO);
  assign hit_low[0] = addr_aligned & (idx == IDX_CH1_LOW);
  assign hit_low[1] = addr_aligned & (idx == IDX_CH2_LOW);
  assign hit_high[0] = addr_aligned & (idx == IDX_CH1_HIGH);
  assign hit_high[1] = addr_aligned & (idx == IDX_CH2_HIGH);
  assign hit_ctrl[0] = addr_aligned & (idx == IDX_CH1_CTRL);
  assign hit_ctrl[1] = addr_aligned & (idx == IDX_CH2_CTRL);
  // unmapped or unaligned words answer with an error and ignore writes
  assign mapped = hit_flags_one | hit_flags_two | hit_en_one | hit_en_two
                | (|hit_low) | (|hit_high) | (|hit_ctrl);

  // both channels are the same hardware; only the trigger use differs [R3]
  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_ch
      logic [15:0] value;
      logic [5:0] ctrl;
      logic [15:0] next_value;
      logic [5:0] next_ctrl;
      logic out_latch;
      logic next_out_latch;
      logic match_prev;
      wire [3:0] mode;
      wire is_capture;
      wire is_compare;
      wire rise;
      wire fall;
      wire tick;
      wire [3:0] term;
      wire capture_evt;
      wire match;
      wire match_hit;
      wire ctrl_zero_wr;

      assign mode = ctrl[3:0];
      // zero is off; only the eight listed codes act [R23]
      assign is_capture = (mode[3:2] == GROUP_CAPTURE);
      assign is_compare = (mode[3:2] == GROUP_COMPARE);

      // the sampler watches the pin itself, so a port write on an output pin
      // can also cause a capture [R8] [R22]
      dcc_edge u_edge (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_pin(i_chan_pin[c]),
        .o_rise(rise),
        .o_fall(fall)
      );

      // divider choice from the mode field [R5]
      assign term = (mode == MODE_CAP_RISE16) ? PRESC_TERM_16 :
                    (mode == MODE_CAP_RISE4) ? PRESC_TERM_4 : PRESC_TERM_1;

      // count held clear outside capture; a direct switch between capture
      // dividers leaves it running [R12] [R13]
      // limitation: after a direct divider switch the first capture may come
      // early, from a count left over by the old divider
      dcc_presc u_presc (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_clear(~is_capture),
        .i_rise(rise),
        .i_term(term),
        .o_tick(tick)
      );

      // qualifying capture event [R5]
      assign capture_evt = is_capture & ((mode == MODE_CAP_FALL) ? fall : tick);

      // equality seen once per match, so a timer that dwells on the value
      // raises one event only [R14]
      assign match = is_compare & (value == i_timer_count);
      assign match_hit = match & ~match_prev;
      // a trigger reset of the timer ends the episode, so the next pass
      // through the value raises a fresh event

      assign ctrl_zero_wr = wr_access & hit_ctrl[c] & (wbyte == 8'h00);

      // value register: capture beats a software byte write in the same cycle
      always_comb begin
        next_value = value;
        if (wr_access & hit_low[c]) begin
          next_value[7:0] = wbyte; // [R2]
        end
        if (wr_access & hit_high[c]) begin
          next_value[15:8] = wbyte; // [R2]
        end
        if (capture_evt) begin
          next_value = i_timer_count; // [R4] [R7]
        end
      end

      // control register: mode and the two duty bits, upper bits read zero
      assign next_ctrl = (wr_access & hit_ctrl[c]) ? wbyte[5:0] : ctrl; // [R2]

      // compare output latch; a zero control write wins over any match
      always_comb begin
        next_out_latch = out_latch;
        if (match_hit & (mode == MODE_CMP_HIGH)) begin
          next_out_latch = 1'b1; // [R15]
        end
        if (match_hit & (mode == MODE_CMP_LOW)) begin
          next_out_latch = 1'b0; // [R15]
        end
        if (ctrl_zero_wr) begin
          next_out_latch = 1'b0; // [R16]
        end
      end

      // channel state
      always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
          value <= VALUE_RESET;
          ctrl <= CTRL_RESET;
          out_latch <= 1'b0;
          match_prev <= 1'b0;
        end else begin
          value <= next_value; // [R1]
          ctrl <= next_ctrl;
          out_latch <= next_out_latch;
          match_prev <= match;
        end
      end

      // soft and special modes leave the latch alone; soft only flags, special also fires the trigger [R17]
      assign set_flag[c] = capture_evt | match_hit; // [R6] [R15]
      assign special_hit[c] = match_hit & (mode == MODE_CMP_SPECIAL);
      assign value_w[c] = value;
      assign ctrl_w[c] = ctrl;
      assign o_chan_out[c] = out_latch;
    end
  endgenerate

  // unimplemented flag bits are not stored and read back as zero
  // flag registers: hardware set wins over a software clear in the same
  // cycle, so no event is lost while software acknowledges another
  always_comb begin
    next_flags_one = flags_one;
    next_flags_two = flags_two;
    if (wr_access & hit_flags_one) begin
      next_flags_one[FLAG_CH1_BIT] = wbyte[FLAG_CH1_BIT];
      next_flags_one[FLAG_TIMER_ONE_COUNT_BIT] = wbyte[FLAG_TIMER_ONE_COUNT_BIT];
    end
    if (wr_access & hit_flags_two) begin
      next_flags_two[FLAG_CH2_BIT] = wbyte[FLAG_CH2_BIT];
    end
    if (set_flag[0]) begin
      next_flags_one[FLAG_CH1_BIT] = 1'b1; // [R6]
    end
    if (set_flag[1]) begin
      next_flags_two[FLAG_CH2_BIT] = 1'b1; // [R6]
    end
    // besides a software write of one, only the timer's own overflow sets its flag, never a trigger reset
    if (i_timer_overflow) begin
      next_flags_one[FLAG_TIMER_ONE_COUNT_BIT] = 1'b1; // [R20]
    end
  end

  // trigger outputs, registered one cycle after the match
  // channel one resets the timer only [R18]; channel two also starts a
  // conversion when the converter is on [R19]
  assign next_timer_reset = special_hit[0] | special_hit[1]; // [R18] [R19]
  assign next_adc_start = special_hit[1] & i_adc_enabled; // [R19]

  // shared register state
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      flags_one <= FLAGS_RESET;
      flags_two <= FLAGS_RESET;
      enables_one <= ENABLES_RESET;
      enables_two <= ENABLES_RESET;
      o_timer_reset <= 1'b0;
      o_adc_start <= 1'b0;
    end else begin
      flags_one <= next_flags_one;
      flags_two <= next_flags_two;
      o_timer_reset <= next_timer_reset;
      o_adc_start <= next_adc_start;
      if (wr_access & hit_en_one) begin
        enables_one <= wbyte;
      end
      if (wr_access & hit_en_two) begin
        enables_two <= wbyte;
      end
    end
  end

  // event requests are gated by the enables; software masks these while
  // it changes the capture mode to hide a false flag [R11]
  assign o_event_req[0] = flags_one[FLAG_CH1_BIT] & enables_one[EN_CH1_BIT];
  assign o_event_req[1] = flags_two[FLAG_CH2_BIT] & enables_two[EN_CH2_BIT];

  // read mux; unimplemented flag bits read zero
  always_comb begin
    rd_byte = 8'h00;
    if (hit_flags_one) begin
      rd_byte[FLAG_CH1_BIT] = flags_one[FLAG_CH1_BIT];
      rd_byte[FLAG_TIMER_ONE_COUNT_BIT] = flags_one[FLAG_TIMER_ONE_COUNT_BIT];
    end
    if (hit_flags_two) begin
      rd_byte[FLAG_CH2_BIT] = flags_two[FLAG_CH2_BIT];
    end
    if (hit_en_one) begin
      rd_byte = enables_one;
    end
    if (hit_en_two) begin
      rd_byte = enables_two;
    end
    if (hit_low[0]) begin
      rd_byte = value_w[0][7:0];
    end
    if (hit_high[0]) begin
      rd_byte = value_w[0][15:8];
    end
    if (hit_ctrl[0]) begin
      rd_byte = {2'h0, ctrl_w[0]};
    end
    if (hit_low[1]) begin
      rd_byte = value_w[1][7:0];
    end
    if (hit_high[1]) begin
      rd_byte = value_w[1][15:8];
    end
    if (hit_ctrl[1]) begin
      rd_byte = {2'h0, ctrl_w[1]};
    end
  end

  assign next_prdata = {24'h000000, rd_byte};

  // read data and error are latched in the setup cycle so they come from
  // flops; a capture landing during the access phase shows on the next read
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_prdata <= 32'h00000000;
      o_pslverr <= 1'b0;
    end else if (setup_phase) begin
      o_prdata <= next_prdata;
      o_pslverr <= ~mapped;
    end
  end
endmodule
`default_nettype wire

//--- verif/dcc_pin_model.sv
// pin model: external event source or port-driven level per channel
`timescale 1ns/1ps
`default_nettype none
module dcc_pin_model (
  // direction and level sources
  input wire logic [1:0] i_dir_in,
  input wire logic [1:0] i_ext_lvl,
  input wire logic [1:0] i_port_lvl,
  // pin levels seen by the unit
  output logic [1:0] o_pin
);
  // an output pin follows the port latch, so a port write can still raise a capture
  assign o_pin = (i_dir_in & i_ext_lvl) | (~i_dir_in & i_port_lvl);
endmodule
`default_nettype wire

//--- verif/dcc_sva.sv
// port assertions for the dual capture/compare unit
`timescale 1ns/1ps
`default_nettype none
module dcc_sva (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // apb side
  input wire dcc_pkg::dcc_apb_req_t i_apb,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // timer, converter and pins
  input wire logic [15:0] i_timer_count,
  input wire logic i_timer_overflow,
  input wire logic o_timer_reset,
  input wire logic i_adc_enabled,
  input wire logic o_adc_start,
  input wire logic [1:0] i_chan_pin,
  input wire logic [1:0] o_chan_out,
  input wire logic [1:0] o_event_req
);
  import dcc_pkg::*;
  // access phase and write strobe seen by the slave
  wire logic acc = i_apb.psel & i_apb.penable;
  wire logic acc_wr = acc & i_apb.pwrite;
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);
  ready_zero_wait_a: assert property (acc |-> o_pready)
    else $error("pready missing in access phase");
  bad_addr_err_a: assert property (acc && i_apb.paddr[1:0] != 2'h0 |-> o_pslverr)
    else $error("unaligned access without error");
  read_byte_only_a: assert property (acc |-> o_prdata[31:8] == 24'h0)
    else $error("read data above byte not zero");
  trig_pulse_a: assert property (o_timer_reset |=> !o_timer_reset)
    else $error("timer reset longer than one cycle");
  adc_with_reset_a: assert property (o_adc_start |-> o_timer_reset)
    else $error("conversion start without timer reset");
  adc_gate_a: assert property (o_adc_start |-> $past(i_adc_enabled) || $past(i_adc_enabled, 2))
    else $error("conversion start while converter off");
  flag_hold_one_a: assert property (o_event_req[0] && !acc_wr |=> o_event_req[0])
    else $error("channel one request dropped without write");
  flag_hold_two_a: assert property (o_event_req[1] && !acc_wr |=> o_event_req[1])
    else $error("channel two request dropped without write");
  reset_quiet_a: assert property ($rose(i_rst_n) |-> o_chan_out == 2'h0 && !o_timer_reset)
    else $error("outputs not cleared by reset");
endmodule
`default_nettype wire

//--- verif/dual_capture_compare_unit_tb.sv
// self-checking bench for the dual capture/compare unit
`timescale 1ns/1ps
`default_nettype none
module dual_capture_compare_unit_tb;
  import dcc_pkg::*;
  localparam logic [7:0] CTL [2] = '{IDX_CH1_CTRL, IDX_CH2_CTRL};
  localparam logic [7:0] FLG [2] = '{IDX_FLAGS_ONE, IDX_FLAGS_TWO};
  localparam logic [7:0] LOW [2] = '{IDX_CH1_LOW, IDX_CH2_LOW};
  localparam logic [7:0] HIGH [2] = '{IDX_CH1_HIGH, IDX_CH2_HIGH};
  localparam logic [31:0] FBIT [2] = '{32'h4, 32'h1};
  localparam logic [7:0] REGS [8] = '{IDX_FLAGS_ONE, IDX_FLAGS_TWO, IDX_CH1_LOW, IDX_CH1_HIGH,
    IDX_CH1_CTRL, IDX_CH2_CTRL, IDX_EN_ONE, IDX_EN_TWO};
  localparam logic [3:0] CM [4] = '{MODE_CMP_HIGH, MODE_CMP_SOFT, MODE_CMP_LOW, MODE_CMP_SPECIAL};
  logic i_sys_clk, i_rst_n, tovf, tres, adc_en, adc_st, pready, pslverr, rerr;
  dcc_apb_req_t apb;
  logic [31:0] prdata, rdat;
  logic [15:0] timer;
  logic [1:0] pin, cout, ereq, dir_in, ext, port;
  int error_cnt, n_checks, trs, ads, n;

  dcc_top u_dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_apb(apb), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_timer_count(timer), .i_timer_overflow(tovf),
    .o_timer_reset(tres), .i_adc_enabled(adc_en), .o_adc_start(adc_st), .i_chan_pin(pin),
    .o_chan_out(cout), .o_event_req(ereq));
  dcc_pin_model u_pins (.i_dir_in(dir_in), .i_ext_lvl(ext), .i_port_lvl(port), .o_pin(pin));

  // 40 mhz clock
  initial begin
    i_sys_clk = 1'b0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end

  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge i_sys_clk);
  endtask

  // one apb transfer; an idle edge follows so the next setup never lands in the same step
  task automatic xfer(input logic wr, input logic [9:0] addr, input logic [7:0] wd);
    int w;
    apb <= '{1'b1, 1'b0, wr, addr, {24'h0, wd}};
    @(posedge i_sys_clk);
    apb.penable <= 1'b1;
    w = 0;
    do begin
      @(posedge i_sys_clk);
      w++;
    end while (pready !== 1'b1 && w < 16);
    if (pready !== 1'b1) begin
      error_cnt++;
      conclude();
    end
    rdat = prdata;
    rerr = pslverr;
    apb <= '0;
    @(posedge i_sys_clk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    xfer(1'b1, {idx, 2'b00}, d);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    xfer(1'b0, {idx, 2'b00}, 8'h00);
    chk(rdat, exp);
  endtask

  // timer walks across 0x1234 once; trigger pulses are counted as they pass
  task automatic cmp_step();
    trs = 0;
    ads = 0;
    timer <= 16'h1233;
    tick(2);
    timer <= 16'h1234;
    tick(1);
    timer <= 16'h1235;
    repeat (4) begin
      @(posedge i_sys_clk);
      trs += int'(tres);
      ads += int'(adc_st);
    end
  endtask

  // hang guard
  initial begin
    tick(60000);
    error_cnt++;
    conclude();
  end

  // main sequence
  initial begin
    apb = '0;
    timer = 16'h0;
    tovf = 1'b0;
    adc_en = 1'b1;
    dir_in = 2'b11;
    ext = 2'b00;
    port = 2'b00;
    i_rst_n = 1'b0;
    tick(16);
    i_rst_n <= 1'b1;
    tick(1);
    for (int i = 0; i < 8; i++) rdc(REGS[i], 32'h0);
    wr(IDX_CH1_CTRL, 8'hff);
    rdc(IDX_CH1_CTRL, 32'h3f);
    wr(IDX_CH2_HIGH, 8'ha5);
    rdc(IDX_CH2_HIGH, 32'ha5);
    xfer(1'b0, 10'h080, 8'h00);
    chk({31'h0, rerr}, 32'h1);
    xfer(1'b0, 10'h055, 8'h00);
    chk({31'h0, rerr}, 32'h1);
    // every capture event on both channels; timer value tags mode, channel and edge
    for (int c = 0; c < 2; c++) begin
      for (int m = 4; m < 8; m++) begin
        ext[c] <= (m == 4);
        wr(CTL[c], 8'h00);
        wr(CTL[c], 8'(m));
        wr(FLG[c], 8'h00);
        n = (m == 6) ? 4 : (m == 7) ? 16 : 1;
        for (int k = 1; k <= n; k++) begin
          if (k == n) rdc(FLG[c], 32'h0);
          timer <= {4'(m), 4'(c), 8'(k)};
          ext[c] <= (m != 4);
          tick(3);
          ext[c] <= (m == 4);
          tick(3);
        end
        rdc(FLG[c], FBIT[c]);
        rdc(LOW[c], {24'h0, 8'(n)});
        rdc(HIGH[c], {24'h0, 4'(m), 4'(c)});
      end
    end
    wr(IDX_EN_ONE, 8'h04);
    wr(IDX_EN_TWO, 8'h01);
    tick(20);
    chk({30'h0, ereq}, 32'h3);
    wr(IDX_FLAGS_TWO, 8'h00);
    chk({30'h0, ereq}, 32'h1);
    // port write on an output pin
    dir_in[0] <= 1'b0;
    wr(CTL[0], {4'h0, MODE_CAP_RISE});
    wr(FLG[0], 8'h00);
    port[0] <= 1'b1;
    tick(3);
    rdc(FLG[0], 32'h4);
    // compare actions on both channels
    for (int c = 0; c < 2; c++) begin
      wr(LOW[c], 8'h34);
      wr(HIGH[c], 8'h12);
      for (int i = 0; i < 4; i++) begin
        wr(CTL[c], {4'h0, CM[i]});
        wr(FLG[c], 8'h00);
        cmp_step();
        chk({31'h0, cout[c]}, 32'(i < 2));
        rdc(FLG[c], FBIT[c]);
        chk(32'(trs), 32'(i == 3));
        chk(32'(ads), 32'(i == 3 && c == 1));
      end
      adc_en <= 1'b0;
      cmp_step();
      chk(32'(ads), 32'h0);
      adc_en <= 1'b1;
      wr(CTL[c], {4'h0, MODE_CMP_HIGH});
      cmp_step();
      chk({31'h0, cout[c]}, 32'h1);
      wr(CTL[c], 8'h00);
      chk({31'h0, cout[c]}, 32'h0);
    end
    rdc(IDX_FLAGS_ONE, 32'h4);
    tovf <= 1'b1;
    tick(1);
    tovf <= 1'b0;
    tick(1);
    rdc(IDX_FLAGS_ONE, 32'h5);
    conclude();
  end
endmodule

bind dcc_top dcc_sva u_sva (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_apb(i_apb),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_timer_count(i_timer_count), .i_timer_overflow(i_timer_overflow),
  .o_timer_reset(o_timer_reset), .i_adc_enabled(i_adc_enabled), .o_adc_start(o_adc_start),
  .i_chan_pin(i_chan_pin), .o_chan_out(o_chan_out), .o_event_req(o_event_req));
`default_nettype wire
